// File: src/ecu_pkg.sv
// Constants, register map and carrier types of the edge capture unit.
// Assumes a 32-bit Avalon-MM register bus with a byte address.
package ecu_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int              ECU_AW          = 4;
	localparam logic [3:0]      ECU_OFS_CTRL    = 4'h0;   // capture_channel_control
	localparam logic [3:0]      ECU_OFS_BUF     = 4'h4;   // oldest captured value, read pops
	localparam logic [3:0]      ECU_OFS_STAT    = 4'h8;   // sticky events, read clears
	localparam logic [3:0]      ECU_OFS_MASK    = 4'hC;   // interrupt mask, same layout

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int              ECU_B_IDLE      = 13;     // idle_stop_select
	localparam int              ECU_B_TSEL      = 7;      // timebase_select
	localparam int              ECU_B_ICI_HI    = 6;      // captures_per_irq
	localparam int              ECU_B_ICI_LO    = 5;
	localparam int              ECU_B_OVF       = 4;      // capture_overflow_flag
	localparam int              ECU_B_BNE       = 3;      // buffer_not_empty_flag
	localparam int              ECU_B_MODE_HI   = 2;      // capture_mode_select
	localparam int              ECU_B_MODE_LO   = 0;
	localparam logic [31:0]     ECU_CTRL_RST    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Status / mask bits
	// ----------------------------------------------------------------
	localparam int              ECU_NEV         = 3;
	localparam int              ECU_EV_CAP      = 0;      // capture interrupt
	localparam int              ECU_EV_OVF      = 1;      // capture overflow
	localparam int              ECU_EV_WAKE     = 2;      // wake-up edge

	// ----------------------------------------------------------------
	// Modes and prescale limits
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ECU_M_OFF   = 3'h0,
		ECU_M_BOTH  = 3'h1,
		ECU_M_FALL  = 3'h2,
		ECU_M_RISE  = 3'h3,
		ECU_M_RISE4 = 3'h4,
		ECU_M_RISE16= 3'h5,
		ECU_M_UNUSED= 3'h6,
		ECU_M_WAKE  = 3'h7
	} ecu_mode_t;

	localparam logic [3:0]      ECU_PRE4_LAST   = 4'h3;
	localparam logic [3:0]      ECU_PRE16_LAST  = 4'hF;
	localparam logic [3:0]      ECU_PRE_ZERO    = 4'h0;

	// Bus request carrier
	typedef struct packed {
		logic                   rd;
		logic                   wr;
		logic [ECU_AW-1:0]      addr;
		logic [3:0]             be;
		logic [31:0]            wdata;
	} ecu_req_t;

	// Control register contents
	typedef struct packed {
		logic                   idle_stop;
		logic                   tsel;
		logic [1:0]             captures_per_irq;
		ecu_mode_t              mode;
	} ecu_ctrl_t;

endpackage

// File: src/ecu_top.sv
// Edge capture unit: one input channel timestamped with a timer count.
// Assumes an Avalon-MM master, a free-running timer count and CPU
// power-state levels, all on core_clk_i.
//
// How it works
// - Idle-stop bit halts channel in CPU idle
// - Each capture latches the second timer count
// - Captures-per-irq field sets interrupt rate
// - Read-only overflow flag, hardware cleared, resets zero
// - Read-only buffer-not-empty flag, resets zero
// - Mode 111: rising-edge wake pin in sleep/idle
// - Mode 111 ignores all other control fields
// - Mode 110 acts as channel disabled
// - Mode 101 every 16th, 100 every 4th rise
// - Mode 011 captures every rising edge
// - Mode 010 captures every falling edge
// - Every-edge mode ignores captures-per-irq field
// - Mode 000 turns the channel off
// - Unimplemented bits read zero, fields reset zero
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module ecu_top
	import ecu_pkg::*;
#(
	parameter int                       DEPTH   = 4,
	parameter int                       TW      = 16
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   ce_i,
	input  wire logic [ECU_AW-1:0]      avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [3:0]             avs_byteenable_i,
	input  wire logic [31:0]            avs_writedata_i,
	output logic [31:0]                 avs_readdata_o,
	output logic                        avs_waitrequest_o,
	input  wire logic                   cap_pin_i,
	input  wire logic [TW-1:0]          second_timer_count_i,
	input  wire logic                   cpu_idle_i,
	input  wire logic                   cpu_sleep_i,
	output logic                        irq_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int                      PW      = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int                      CW      = $clog2(DEPTH + 1);
	localparam logic [CW-1:0]           CNT_FULL = CW'(DEPTH);
	localparam logic [CW-1:0]           CNT_ONE  = CW'(1);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("DEPTH must be a power of two, at least 2");
		if (TW < 1 || TW > 32)
			$error("TW must lie between 1 and 32");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0]                         rst_sync_ff;
	logic                               rst_n;

	// Async assert, two-flop release
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	ecu_req_t                           req;
	logic                               ack_ff;
	logic                               take;
	logic                               rd_take;
	logic                               wr_take;
	logic                               sel_ctrl;
	logic                               sel_buf;
	logic                               sel_stat;
	logic                               sel_mask;
	logic [31:0]                        rd_mux;
	logic [31:0]                        ctrl_rd;

	assign req       = '{rd: avs_read_i, wr: avs_write_i, addr: avs_address_i,
	                     be: avs_byteenable_i, wdata: avs_writedata_i};
	// One wait cycle: read data is registered before the answer
	assign avs_waitrequest_o = (req.rd || req.wr) && !ack_ff;
	assign take      = ce_i && ack_ff && (req.rd || req.wr);
	assign rd_take   = take && req.rd;
	assign wr_take   = take && req.wr;
	assign sel_ctrl  = (req.addr == ECU_OFS_CTRL);
	assign sel_buf   = (req.addr == ECU_OFS_BUF);
	assign sel_stat  = (req.addr == ECU_OFS_STAT);
	assign sel_mask  = (req.addr == ECU_OFS_MASK);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			ack_ff <= 1'b0;
		else if (ce_i)
			ack_ff <= (req.rd || req.wr) && !ack_ff;
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	ecu_ctrl_t                          ctrl_ff;
	ecu_ctrl_t                          nxt_ctrl;
	logic [ECU_NEV-1:0]                 mask_ff;
	logic [ECU_NEV-1:0]                 stat_ff;
	logic                               ovf_ff;
	logic [CW-1:0]                      cnt_ff;
	logic                               bne;

	// Byte lanes 0 and 1 only; upper lanes hold nothing
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (req.be[0]) begin
			nxt_ctrl.tsel = req.wdata[ECU_B_TSEL];
			nxt_ctrl.captures_per_irq  = req.wdata[ECU_B_ICI_HI:ECU_B_ICI_LO];
			nxt_ctrl.mode = ecu_mode_t'(req.wdata[ECU_B_MODE_HI:ECU_B_MODE_LO]);
		end
		if (req.be[1])
			nxt_ctrl.idle_stop = req.wdata[ECU_B_IDLE];
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= ecu_ctrl_t'(ECU_CTRL_RST[6:0]);
			mask_ff <= '0;
		end else if (ce_i && wr_take) begin
			if (sel_ctrl)
				ctrl_ff <= nxt_ctrl;
			if (sel_mask && req.be[0])
				mask_ff <= req.wdata[ECU_NEV-1:0];
		end
	end

	// Unimplemented positions assembled as zero
	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[ECU_B_IDLE] = ctrl_ff.idle_stop;
		ctrl_rd[ECU_B_TSEL] = ctrl_ff.tsel;
		ctrl_rd[ECU_B_ICI_HI:ECU_B_ICI_LO] = ctrl_ff.captures_per_irq;
		ctrl_rd[ECU_B_OVF] = ovf_ff;
		ctrl_rd[ECU_B_BNE] = bne;
		ctrl_rd[ECU_B_MODE_HI:ECU_B_MODE_LO] = ctrl_ff.mode;
	end

	// ----------------------------------------------------------------
	// Input synchroniser and edge detect
	// ----------------------------------------------------------------
	logic [2:0]                         sync_ff;
	logic                               level_ff;
	logic                               agree;
	logic                               rise;
	logic                               fall;

	// Edge counts only once the last two stages agree
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_ff  <= 3'h0;
			level_ff <= 1'b0;
		end else if (ce_i) begin
			sync_ff <= {sync_ff[1:0], cap_pin_i};
			if (agree)
				level_ff <= sync_ff[2];
		end
	end
	assign agree = (sync_ff[1] == sync_ff[2]);
	assign rise  = ce_i && agree && sync_ff[2] && !level_ff;
	assign fall  = ce_i && agree && !sync_ff[2] && level_ff;

	// ----------------------------------------------------------------
	// Capture event selection
	// ----------------------------------------------------------------
	logic                               halted;
	logic                               presc_mode;
	logic [3:0]                         pre_last;
	logic [3:0]                         pre_ff;
	logic                               pre_hit;
	logic                               cap_evt;
	logic                               wake_set;

	// Mode 111 ignores the idle-stop bit; other modes honour it
	assign halted     = ctrl_ff.idle_stop && cpu_idle_i;
	assign presc_mode = (ctrl_ff.mode == ECU_M_RISE4) || (ctrl_ff.mode == ECU_M_RISE16);
	assign pre_last   = (ctrl_ff.mode == ECU_M_RISE16) ? ECU_PRE16_LAST : ECU_PRE4_LAST;
	assign pre_hit    = rise && (pre_ff == pre_last);

	always_comb begin
		cap_evt = 1'b0;
		case (ctrl_ff.mode)
			ECU_M_BOTH:   cap_evt = rise || fall;
			ECU_M_FALL:   cap_evt = fall;
			ECU_M_RISE:   cap_evt = rise;
			ECU_M_RISE4,
			ECU_M_RISE16: cap_evt = pre_hit;
			default:      cap_evt = 1'b0;
		endcase
		if (halted)
			cap_evt = 1'b0;
	end

	// Wake pin: rising edges only, only while asleep or idle
	assign wake_set = (ctrl_ff.mode == ECU_M_WAKE) && rise && (cpu_sleep_i || cpu_idle_i);

	// Prescaler restarts whenever the mode leaves the divided modes
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			pre_ff <= ECU_PRE_ZERO;
		else if (ce_i && !presc_mode)
			pre_ff <= ECU_PRE_ZERO;
		else if (rise && !halted)
			pre_ff <= pre_hit ? ECU_PRE_ZERO : pre_ff + 4'h1;
	end

	// ----------------------------------------------------------------
	// Interrupt rate counter
	// ----------------------------------------------------------------
	logic [1:0]                         ici_ff;
	logic [1:0]                         ici_last;
	logic                               cap_irq;

	// Every-edge mode interrupts on each capture else field+1
	assign ici_last = (ctrl_ff.mode == ECU_M_BOTH) ? 2'h0 : ctrl_ff.captures_per_irq;
	assign cap_irq  = cap_evt && (ici_ff >= ici_last);      // A lowered field never skips a turn

	// Held at zero in every-edge mode so a stale count cannot delay it
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			ici_ff <= 2'h0;
		else if (ce_i && (ctrl_ff.mode == ECU_M_OFF || ctrl_ff.mode == ECU_M_BOTH))
			ici_ff <= 2'h0;
		else if (cap_evt)
			ici_ff <= cap_irq ? 2'h0 : ici_ff + 2'h1;
	end

	// ----------------------------------------------------------------
	// Capture FIFO
	// ----------------------------------------------------------------
	logic [TW-1:0]                      mem_ff [DEPTH];
	logic [PW-1:0]                      wp_ff;
	logic [PW-1:0]                      rp_ff;
	logic                               full;
	logic                               push;
	logic                               pop;
	logic                               ovf_set;
	logic                               ovf_clr;
	logic                               buf_vld_ff;

	assign full    = (cnt_ff == CNT_FULL);
	assign bne     = (cnt_ff != '0);
	assign push    = cap_evt && !full;
	assign pop     = rd_take && sel_buf && buf_vld_ff;
	assign ovf_set = cap_evt && full;
	assign ovf_clr = pop && !push && (cnt_ff == CNT_ONE);

	// Timer count latched on each accepted capture
	always_ff @(posedge core_clk_i) begin
		if (push)
			mem_ff[wp_ff] <= second_timer_count_i;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push)
				wp_ff <= wp_ff + PW'(1);
			if (pop)
				rp_ff <= rp_ff + PW'(1);
			if (push != pop)
				cnt_ff <= push ? cnt_ff + CW'(1) : cnt_ff - CW'(1);
		end
	end

	// Overflow set wins over the clear
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			ovf_ff <= 1'b0;
		else if (ovf_set)
			ovf_ff <= 1'b1;
		else if (ovf_clr)
			ovf_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------------------------------
	logic [ECU_NEV-1:0]                 ev_set;
	logic [ECU_NEV-1:0]                 ev_clr;

	assign ev_set[ECU_EV_CAP]  = cap_irq;
	assign ev_set[ECU_EV_OVF]  = ovf_set;
	assign ev_set[ECU_EV_WAKE] = wake_set;
	assign ev_clr = (rd_take && sel_stat) ? avs_readdata_o[ECU_NEV-1:0] : '0;

	// Read clears only the bits it returned; a later event survives
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			stat_ff <= '0;
		else if (ce_i)
			stat_ff <= (stat_ff & ~ev_clr) | ev_set;
	end
	assign irq_o = |(stat_ff & mask_ff);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Registered in the wait cycle; unmapped reads give zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl)
			rd_mux = ctrl_rd;
		else if (sel_buf && bne)
			rd_mux[TW-1:0] = mem_ff[rp_ff];
		else if (sel_stat)
			rd_mux[ECU_NEV-1:0] = stat_ff;
		else if (sel_mask)
			rd_mux[ECU_NEV-1:0] = mask_ff;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h0000_0000;
			buf_vld_ff     <= 1'b0;
		end else if (ce_i && req.rd && !ack_ff) begin
			avs_readdata_o <= rd_mux;
			buf_vld_ff     <= sel_buf && bne;                 // Pop only a value that was shown
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	idle_halt_a: assert property (halted && ctrl_ff.mode != ECU_M_WAKE |-> !cap_evt)
		else $error("capture taken while halted in idle");
	timer_latch_a: assert property (push |=> mem_ff[$past(wp_ff)] == $past(second_timer_count_i))
		else $error("stored value differs from timer count");
	irq_rate_a: assert property (cap_evt && ctrl_ff.mode != ECU_M_BOTH && ctrl_ff.captures_per_irq == 2'h3
		&& ici_ff != 2'h3 |-> !ev_set[ECU_EV_CAP])
		else $error("interrupt before fourth capture");
	ovf_flag_a: assert property (ovf_set |=> ovf_ff && (full || $past(pop)))
		else $error("overflow flag not set on full capture");
	bne_clear_a: assert property (ovf_clr |=> !bne && !ovf_ff)
		else $error("flags not cleared after last pop");
	wake_edge_a: assert property (stat_ff[ECU_EV_WAKE] && !$past(stat_ff[ECU_EV_WAKE])
		|-> $past(ctrl_ff.mode) == ECU_M_WAKE && $past(sync_ff[2]))
		else $error("wake event without rising edge in wake mode");
	wake_only_a: assert property (ctrl_ff.mode == ECU_M_WAKE |-> !cap_evt && !push)
		else $error("capture taken in wake mode");
	unused_mode_a: assert property (ctrl_ff.mode == ECU_M_UNUSED |=> $stable(cnt_ff) || $past(pop))
		else $error("capture stored in unused mode");
	every16_a: assert property (cap_evt && ctrl_ff.mode == ECU_M_RISE16 |-> pre_ff == ECU_PRE16_LAST)
		else $error("divided capture off count");
	rise_only_a: assert property (cap_evt && ctrl_ff.mode == ECU_M_RISE |-> rise)
		else $error("rising mode captured a non-rising edge");
	fall_only_a: assert property (cap_evt && ctrl_ff.mode == ECU_M_FALL |-> fall)
		else $error("falling mode captured a non-falling edge");
	both_irq_a: assert property (cap_evt && ctrl_ff.mode == ECU_M_BOTH |-> cap_irq)
		else $error("every-edge capture without interrupt");
	mode_off_a: assert property (ctrl_ff.mode == ECU_M_OFF |-> !cap_evt && !ev_set[ECU_EV_CAP])
		else $error("activity while channel off");
	ctrl_zero_a: assert property (rd_take && sel_ctrl |-> avs_readdata_o[31:14] == '0
		&& avs_readdata_o[12:8] == '0)
		else $error("unimplemented control bits read nonzero");
	fifo_order_a: assert property (pop |-> avs_readdata_o[TW-1:0] == mem_ff[rp_ff])
		else $error("buffer read is not the oldest entry");
	sync_once_a: assert property (rise |=> !rise)
		else $error("one edge counted twice");
	bus_answer_a: assert property ((req.rd || req.wr) && ce_i && !ack_ff |=> !avs_waitrequest_o)
		else $error("bus answer later than one wait cycle");

	overflow_c: cover property (ovf_set);
	wake_c: cover property (wake_set);
	div16_c: cover property (cap_evt && ctrl_ff.mode == ECU_M_RISE16);
	irq_c: cover property (irq_o && ctrl_ff.captures_per_irq == 2'h3);

endmodule

// File: test/ecu_edge_src.sv
// Partner model: the external digital input whose edges get timestamped.
// Assumes its caller is just past a rising edge of clk_i when it asks for a pulse.
`timescale 1ns/1ps

module ecu_edge_src (
	input  wire logic clk_i,
	output logic      pin_o
);
	// Line idles low between pulses, like a pulled-down input
	initial pin_o = 1'b0;

	// One high pulse; both levels stay long enough for the synchroniser
	task automatic pulse(input int hi, input int lo);
		pin_o <= 1'b1;
		repeat (hi) @(posedge clk_i);
		pin_o <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the edge capture unit: Avalon-MM master, timer, power states.
// Assumes ecu_pkg and ecu_top compiled first, and the edge source model beside it.
`timescale 1ns/1ps

module tb;
	import ecu_pkg::*;
	logic                core_clk_i = 1'b0;
	logic                rst_n_i    = 1'b0;
	logic [ECU_AW-1:0]   avs_address_i = '0;
	logic                avs_read_i = 1'b0;
	logic                avs_write_i = 1'b0;
	logic [31:0]         avs_writedata_i = '0;
	logic [31:0]         avs_readdata_o;
	logic                avs_waitrequest_o;
	logic                cap_pin;
	logic [15:0]         timer_cnt = '0;
	logic [15:0]         t0;
	logic                ce_i       = 1'b1;
	// Launch edge, then three sync stages, before the value is stored; the edge flop loads on the storing edge
	localparam logic [15:0] CAP_LAT = 16'h0004;
	logic                cpu_idle_i = 1'b0;
	logic                cpu_sleep_i = 1'b0;
	logic                irq_o;
	logic [31:0]         r;
	int                  err_count = 0;
	int                  checked = 0;
	int                  n;

	// ----------------------------------------------------------------
	// Clock, timer and instances
	// ----------------------------------------------------------------
	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) timer_cnt <= timer_cnt + 16'h0001;

	ecu_edge_src u_ecu_edge_src (.clk_i(core_clk_i), .pin_o(cap_pin));
	ecu_top u_ecu_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .cap_pin_i(cap_pin), .second_timer_count_i(timer_cnt),
		.cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .irq_o(irq_o));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 20);
		q = avs_readdata_o;
		if (k >= 20) begin
			err_count++;
			test_done();
		end
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// Random pulse widths, always above the two-cycle minimum
	task automatic pulse;
		u_ecu_edge_src.pulse(3 + $urandom % 4, 6 + $urandom % 4);
	endtask

	// Pop until empty; values come out oldest first, overflow gone afterwards
	task automatic drain(input int expn);
		logic [31:0] c, v, pv;
		int k;
		k = 0;
		pv = '0;
		bus(0, ECU_OFS_CTRL, 0, c);
		while (c[ECU_B_BNE] === 1'b1 && k < 8) begin
			bus(0, ECU_OFS_BUF, 0, v);
			chk("buffer upper bits", 0, {16'h0000, v[31:16]});
			if (k > 0)
				chk("capture order", 1, {31'h0, (v[15:0] - pv[15:0]) < 16'h1000});
			pv = v;
			k++;
			bus(0, ECU_OFS_CTRL, 0, c);
		end
		chk("capture count", expn, k);
		chk("overflow after drain", 0, {31'h0, c[ECU_B_OVF]});
	endtask

	// Captures expected from p pulses in mode m
	function automatic int exp_caps(input int m, input int p);
		case (m)
			1: return 2 * p;
			2, 3: return p;
			4: return p / 4;
			5: return p / 16;
			default: return 0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge core_clk_i);
		err_count++;
		test_done();
	end

	initial begin
		void'($urandom(32'h252b));
		timer_cnt = 16'($urandom);
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		// Reset values, unimplemented bits, read-only flags, unmapped place
		bus(0, ECU_OFS_CTRL, 0, r); chk("ctrl reset", ECU_CTRL_RST, r);
		bus(1, ECU_OFS_CTRL, 32'hFFFFFFFF, r);
		bus(0, ECU_OFS_CTRL, 0, r); chk("ctrl writable", 32'h000020E7, r);
		bus(0, 4'h2, 0, r); chk("unmapped read", 0, r);
		bus(1, ECU_OFS_CTRL, 0, r);
		// Mode codes 000 to 110 with sixteen pulses; FIFO holds four
		for (int m = 0; m < 7; m++) begin
			bus(1, ECU_OFS_CTRL, 32'h80 | m, r);
			repeat (16) pulse();
			n = exp_caps(m, 16);
			bus(0, ECU_OFS_CTRL, 0, r);
			chk("overflow flag", n > 4, {31'h0, r[ECU_B_OVF]});
			chk("not empty flag", n > 0, {31'h0, r[ECU_B_BNE]});
			drain(n > 4 ? 4 : n);
			bus(1, ECU_OFS_CTRL, 0, r);
		end
		bus(0, ECU_OFS_STAT, 0, r);
		bus(0, ECU_OFS_STAT, 0, r); chk("status cleared", 0, r);
		// Interrupt rate per captures-per-irq code
		bus(1, ECU_OFS_MASK, 32'h1, r);
		for (int c = 0; c < 4; c++) begin
			bus(1, ECU_OFS_CTRL, 32'h80 | (c << 5), r);
			bus(1, ECU_OFS_CTRL, 32'h83 | (c << 5), r);
			for (int i = 0; i < 4; i++) begin
				pulse();
				chk("irq level", ((i + 1) % (c + 1)) == 0, {31'h0, irq_o});
				bus(0, ECU_OFS_STAT, 0, r);
				chk("capture irq bit", ((i + 1) % (c + 1)) == 0, {31'h0, r[ECU_EV_CAP]});
				drain(1);
			end
		end
		// Every-edge mode ignores the rate field
		bus(1, ECU_OFS_CTRL, 32'h60, r);
		bus(1, ECU_OFS_CTRL, 32'h61, r);
		pulse();
		bus(0, ECU_OFS_STAT, 0, r); chk("every edge irq", 1, {31'h0, r[ECU_EV_CAP]});
		drain(2);
		// Idle stop halts, clear bit keeps running in idle
		cpu_idle_i <= 1'b1;
		bus(1, ECU_OFS_CTRL, 32'h2003, r);
		pulse();
		drain(0);
		bus(1, ECU_OFS_CTRL, 32'h3, r);
		t0 = timer_cnt;
		pulse();
		bus(0, ECU_OFS_BUF, 0, r); chk("capture stamp", {16'h0000, t0 + CAP_LAT}, r);
		drain(0);
		bus(0, ECU_OFS_BUF, 0, r); chk("empty buffer read", 0, r);
		// Clock enable low freezes the channel, so a pulse then leaves no trace
		ce_i <= 1'b0;
		pulse();
		ce_i <= 1'b1;
		drain(0);
		cpu_idle_i <= 1'b0;
		// Wake pin: rising edge in sleep sets it, none while awake; other fields ignored
		bus(1, ECU_OFS_MASK, 32'h4, r);
		bus(0, ECU_OFS_MASK, 0, r); chk("mask readback", 32'h4, r);
		bus(0, ECU_OFS_STAT, 0, r);
		bus(1, ECU_OFS_CTRL, 32'hE7, r);
		cpu_sleep_i <= 1'b1;
		pulse();
		chk("wake irq", 1, {31'h0, irq_o});
		bus(0, ECU_OFS_STAT, 0, r); chk("wake bit", 1, {31'h0, r[ECU_EV_WAKE]});
		drain(0);
		cpu_sleep_i <= 1'b0;
		pulse();
		bus(0, ECU_OFS_STAT, 0, r); chk("wake awake", 0, {31'h0, r[ECU_EV_WAKE]});
		chk("irq low", 0, {31'h0, irq_o});
		test_done();
	end
endmodule
